// ---- bdsc_bkpt_match.sv ----
// Breakpoint address comparator with force/tag qualification
`timescale 1ns/100ps
`default_nettype none
module bdsc_bkpt_match #(
  parameter int unsigned AW = 16
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          arst_n,
  // Control
  input  wire logic          bkpt_en,
  input  wire logic          force_tag,
  input  wire logic [AW-1:0] match_value,
  // CPU side
  input  wire logic [AW-1:0] cpu_addr,
  input  wire logic          cpu_fetch,
  input  wire logic          queue_end,
  input  wire logic          queue_end_tagged,
  // Results
  output logic               force_req,
  output logic               tag_out,
  output logic               tag_req
);
  import bdsc_pkg::*;
  logic hit;

  assign hit = bkpt_en && (cpu_addr == match_value);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      force_req <= 1'b0;
    end else begin
      force_req <= hit && (force_tag == FTS_FORCE);
    end
  end

  assign tag_out = hit && (force_tag == FTS_TAG) && cpu_fetch;
  assign tag_req = bkpt_en && (force_tag == FTS_TAG) && queue_end && queue_end_tagged;
endmodule
`default_nettype wire

// ---- bdsc_host.sv ----
// Debug host model issuing serial control-write and status-read commands
`timescale 1ns/100ps
`default_nettype none
module bdsc_host (
  // Clock
  input  wire logic       clk,
  // Commands
  output logic            wr,
  output logic            rd,
  output logic [7:0]      wdata,
  output logic            bgnd,
  output logic            go,
  // Answers
  input  wire logic [7:0] rdata,
  input  wire logic       valid
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
    bgnd = 1'b0;
    go = 1'b0;
  end
  task automatic write_ctrl(input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    // Released data inverted so stale values never pass
    wdata = ~d;
  endtask
  task automatic read_status(output logic [7:0] q);
    @(negedge clk);
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    q = (valid === 1'b1) ? rdata : 8'hXX;
  endtask
  task automatic pulse(input logic sel_go);
    @(negedge clk);
    go = sel_go;
    bgnd = ~sel_go;
    @(negedge clk);
    go = 1'b0;
    bgnd = 1'b0;
  endtask
  task automatic open_session();
    write_ctrl(8'h80);
  endtask
endmodule
`default_nettype wire

// ---- bdsc_pkg.sv ----
// Package: debug status/control field layout and encodings
package bdsc_pkg;
  localparam int unsigned REG_W          = 8;
  localparam int unsigned ADDR_W         = 16;
  localparam int unsigned BIT_PERMIT     = 7;
  localparam int unsigned BIT_ACTIVE     = 6;
  localparam int unsigned BIT_BKPT_EN    = 5;
  localparam int unsigned BIT_FORCE_TAG  = 4;
  localparam int unsigned BIT_CLK_SEL    = 3;
  localparam logic [7:0]  CTRL_WR_MASK   = 8'hB8;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic        CLK_SEL_ALT    = 1'b0;
  localparam logic        CLK_SEL_BUS    = 1'b1;
  localparam logic        FTS_TAG        = 1'b0;
  localparam logic        FTS_FORCE      = 1'b1;
  typedef enum logic [1:0] {BDSC_RUN, BDSC_PEND, BDSC_ACTIVE} bdsc_state_t;
endpackage

// ---- bdsc_top.sv ----
// Background debug status/control register and breakpoint entry logic
//
// Contract
// - The register is reached only by the serial status-read and control-write commands.
// - Permit bit 7 low blocks background entry, high allows it.
// - Permit bit once set stays set until system reset.
// - Bit 6 is a read-only flag, high only while background mode is active.
// - Bit 5 enables the breakpoint; clear makes select bit and match value ignored.
// - Force select with address match enters background at the next boundary.
// - Tag select marks the fetched opcode and enters background when it reaches execution.
// - Bit 3 resets to 0 for the alternate clock, 1 selects the bus clock.
`timescale 1ns/100ps
`default_nettype none
module bdsc_top #(
  parameter int unsigned AW = bdsc_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                          CORE_CLK,
  input  wire logic                          ARST_N,
  // Serial command decoder side
  input  wire logic                          CMD_WRITE_CONTROL,
  input  wire logic                          CMD_READ_STATUS,
  input  wire logic [bdsc_pkg::REG_W-1:0]    CMD_WDATA,
  output logic      [bdsc_pkg::REG_W-1:0]    STATUS_RDATA,
  output logic                               STATUS_VALID,
  // Background entry and exit requests
  input  wire logic                          BACKGROUND_CMD,
  input  wire logic                          GO_CMD,
  // CPU side
  input  wire logic [AW-1:0]                 CPU_ADDR,
  input  wire logic                          CPU_FETCH,
  input  wire logic                          INSTR_BOUNDARY,
  input  wire logic                          QUEUE_END,
  input  wire logic                          QUEUE_END_TAGGED,
  input  wire logic [AW-1:0]                 BREAKPOINT_MATCH_VALUE,
  output logic                               OPCODE_TAG,
  output logic                               CPU_HALT,
  output logic                               COMM_CLOCK_SELECT
);
  import bdsc_pkg::*;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic        background_permit_reg;
  logic        breakpoint_enable_reg;
  logic        force_tag_select_reg;
  logic        comm_clock_select_reg;
  bdsc_state_t state_reg;
  bdsc_state_t state_next;
  logic        force_req;
  logic        tag_req;
  logic        background_active_flag;
  logic [REG_W-1:0] status_word;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      background_permit_reg <= CTRL_RESET[BIT_PERMIT];
    end else if (CMD_WRITE_CONTROL && CMD_WDATA[BIT_PERMIT]) begin
      background_permit_reg <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      breakpoint_enable_reg <= CTRL_RESET[BIT_BKPT_EN];
      force_tag_select_reg  <= CTRL_RESET[BIT_FORCE_TAG];
      comm_clock_select_reg <= CLK_SEL_ALT;
    end else if (CMD_WRITE_CONTROL) begin
      breakpoint_enable_reg <= CMD_WDATA[BIT_BKPT_EN];
      force_tag_select_reg  <= CMD_WDATA[BIT_FORCE_TAG];
      comm_clock_select_reg <= CMD_WDATA[BIT_CLK_SEL];
    end
  end

  // ----------------------------------------
  // Breakpoint comparator
  // ----------------------------------------
  bdsc_bkpt_match #(
    .AW(AW)
  ) u_match (
    .clk              (CORE_CLK),
    .arst_n           (ARST_N),
    .bkpt_en          (breakpoint_enable_reg),
    .force_tag        (force_tag_select_reg),
    .match_value      (BREAKPOINT_MATCH_VALUE),
    .cpu_addr         (CPU_ADDR),
    .cpu_fetch        (CPU_FETCH),
    .queue_end        (QUEUE_END),
    .queue_end_tagged (QUEUE_END_TAGGED),
    .force_req        (force_req),
    .tag_out          (OPCODE_TAG),
    .tag_req          (tag_req)
  );

  // ----------------------------------------
  // Background mode state
  // ----------------------------------------
  // Force requests wait for the boundary; requests are ignored while permit is low
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BDSC_RUN: begin
        if (background_permit_reg) begin
          if (tag_req || (BACKGROUND_CMD && INSTR_BOUNDARY)) begin
            state_next = BDSC_ACTIVE;
          end else if ((force_req && breakpoint_enable_reg) || BACKGROUND_CMD) begin
            state_next = INSTR_BOUNDARY ? BDSC_ACTIVE : BDSC_PEND;
          end
        end
      end
      BDSC_PEND: begin
        if (INSTR_BOUNDARY) begin
          state_next = BDSC_ACTIVE;
        end
      end
      BDSC_ACTIVE: begin
        if (GO_CMD) begin
          state_next = BDSC_RUN;
        end
      end
      default: state_next = BDSC_RUN;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= BDSC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  assign background_active_flag = (state_reg == BDSC_ACTIVE);
  assign CPU_HALT               = background_active_flag;
  assign COMM_CLOCK_SELECT      = comm_clock_select_reg;

  // ----------------------------------------
  // Status read
  // ----------------------------------------
  // Reserved bits read zero
  always_comb begin
    status_word                = '0;
    status_word[BIT_PERMIT]    = background_permit_reg;
    status_word[BIT_ACTIVE]    = background_active_flag;
    status_word[BIT_BKPT_EN]   = breakpoint_enable_reg;
    status_word[BIT_FORCE_TAG] = force_tag_select_reg;
    status_word[BIT_CLK_SEL]   = comm_clock_select_reg;
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      STATUS_RDATA <= CTRL_RESET;
      STATUS_VALID <= 1'b0;
    end else begin
      STATUS_VALID <= CMD_READ_STATUS;
      if (CMD_READ_STATUS) begin
        STATUS_RDATA <= status_word;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence permit_set_s;
    CMD_WRITE_CONTROL && CMD_WDATA[BIT_PERMIT];
  endsequence

  // Force hit seen while running with entry allowed
  sequence force_hit_s;
    force_req && breakpoint_enable_reg && background_permit_reg && state_reg == BDSC_RUN;
  endsequence

  read_valid_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CMD_READ_STATUS |=> STATUS_VALID)
    else $error("status read not answered");

  // Off-boundary hit must be held, not lost
  force_pend_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    force_hit_s ##0 (!INSTR_BOUNDARY && !tag_req) |=> state_reg == BDSC_PEND)
    else $error("force breakpoint dropped");

  permit_sticky_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    permit_set_s |=> background_permit_reg [*8])
    else $error("permit bit dropped");

  no_entry_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !background_permit_reg |=> !background_active_flag)
    else $error("background entered without permit");

  flag_read_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CMD_READ_STATUS |=> STATUS_RDATA[BIT_ACTIVE] == $past(background_active_flag))
    else $error("active flag misreported");

  bkpt_off_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !breakpoint_enable_reg |-> !OPCODE_TAG && !tag_req)
    else $error("breakpoint acted while disabled");

  force_entry_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    force_hit_s ##0 INSTR_BOUNDARY |=> background_active_flag)
    else $error("force breakpoint missed boundary");

  tag_entry_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    tag_req && background_permit_reg && state_reg == BDSC_RUN |=> background_active_flag)
    else $error("tagged opcode executed");

  clk_sel_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CMD_WRITE_CONTROL |=> COMM_CLOCK_SELECT == $past(CMD_WDATA[BIT_CLK_SEL]))
    else $error("clock select not written");

  reserved_zero_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    STATUS_VALID |-> (STATUS_RDATA & ~CTRL_WR_MASK & ~(8'h01 << BIT_ACTIVE)) == 8'h00)
    else $error("reserved bits not zero");
endmodule
`default_nettype wire

// ---- bdsc_top_tb.sv ----
// Testbench for the debug status/control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module bdsc_top_tb;
  import bdsc_pkg::*;
  logic clk, arst_n, wr, rd, bgnd, go, valid, tag, halt, csel;
  logic fetch, bnd, qend, qtag;
  logic [7:0] wdata, rdata, q;
  logic [15:0] addr, mval;
  int n_errors = 0, n_tests = 0;
  always #4 clk = ~clk;
  bdsc_host host (.clk(clk), .wr(wr), .rd(rd), .wdata(wdata), .bgnd(bgnd), .go(go),
    .rdata(rdata), .valid(valid));
  bdsc_top DUT (.CORE_CLK(clk), .ARST_N(arst_n), .CMD_WRITE_CONTROL(wr),
    .CMD_READ_STATUS(rd), .CMD_WDATA(wdata), .STATUS_RDATA(rdata), .STATUS_VALID(valid),
    .BACKGROUND_CMD(bgnd), .GO_CMD(go), .CPU_ADDR(addr), .CPU_FETCH(fetch),
    .INSTR_BOUNDARY(bnd), .QUEUE_END(qend), .QUEUE_END_TAGGED(qtag),
    .BREAKPOINT_MATCH_VALUE(mval), .OPCODE_TAG(tag), .CPU_HALT(halt),
    .COMM_CLOCK_SELECT(csel));
  task automatic do_reset();
    @(negedge clk);
    arst_n = 1'b0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
  endtask
  task automatic wait_halt(input logic e);
    for (int i = 0; i < 4 && halt !== e; i++) @(negedge clk);
    `CHK("halt", e, halt)
  endtask
  task automatic t_reg();
    host.read_status(q);
    `CHK("reset word", CTRL_RESET, q)
    `CHK("clk sel", CLK_SEL_ALT, csel)
    host.write_ctrl(8'hFF);
    host.read_status(q);
    `CHK("masked word", CTRL_WR_MASK, q)
    `CHK("clk sel", CLK_SEL_BUS, csel)
    host.write_ctrl(8'h00);
    host.read_status(q);
    `CHK("sticky permit", 8'h80, q)
    do_reset();
    host.read_status(q);
    `CHK("permit cleared", 8'h00, q)
    $display("test reg done");
  endtask
  task automatic t_permit();
    bnd = 1'b1;
    host.pulse(1'b0);
    repeat (4) @(negedge clk);
    `CHK("blocked", 1'b0, halt)
    host.open_session();
    repeat (2) @(negedge clk);
    `CHK("no pending", 1'b0, halt)
    bnd = 1'b0;
    host.pulse(1'b0);
    repeat (2) @(negedge clk);
    `CHK("entry waits", 1'b0, halt)
    bnd = 1'b1;
    wait_halt(1'b1);
    host.read_status(q);
    `CHK("active flag", 1'b1, q[BIT_ACTIVE])
    host.pulse(1'b1);
    wait_halt(1'b0);
    host.read_status(q);
    `CHK("flag idle", 1'b0, q[BIT_ACTIVE])
    $display("test permit done");
  endtask
  task automatic t_force();
    host.write_ctrl(8'hB0);
    bnd = 1'b0;
    addr = mval;
    @(negedge clk);
    addr = 16'h0000;
    repeat (2) @(negedge clk);
    `CHK("force waits", 1'b0, halt)
    bnd = 1'b1;
    wait_halt(1'b1);
    host.pulse(1'b1);
    wait_halt(1'b0);
    addr = mval;
    @(negedge clk);
    addr = 16'h0000;
    wait_halt(1'b1);
    host.pulse(1'b1);
    wait_halt(1'b0);
    host.write_ctrl(8'h90);
    addr = mval;
    fetch = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("disabled bkpt", 1'b0, halt)
    host.write_ctrl(8'h80);
    `CHK("no tag", 1'b0, tag)
    fetch = 1'b0;
    addr = 16'h0000;
    $display("test force done");
  endtask
  task automatic t_tag();
    mval = 16'hC35A;
    host.write_ctrl(8'hA0);
    addr = mval;
    fetch = 1'b1;
    #1;
    `CHK("tag out", 1'b1, tag)
    @(negedge clk);
    fetch = 1'b0;
    addr = 16'h0000;
    repeat (3) @(negedge clk);
    `CHK("no entry yet", 1'b0, halt)
    qend = 1'b1;
    @(negedge clk);
    qend = 1'b0;
    @(negedge clk);
    `CHK("untagged end", 1'b0, halt)
    qend = 1'b1;
    qtag = 1'b1;
    @(negedge clk);
    qend = 1'b0;
    qtag = 1'b0;
    wait_halt(1'b1);
    $display("test tag done");
  endtask
  task automatic wrap_up();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    wrap_up();
  end
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    fetch = 1'b0;
    bnd = 1'b0;
    qend = 1'b0;
    qtag = 1'b0;
    addr = 16'h0000;
    mval = 16'h1234;
    do_reset();
    t_reg();
    t_permit();
    t_force();
    t_tag();
    wrap_up();
  end
endmodule
`default_nettype wire
